/* File: core/cfg_serial_port.sv */
// configuration serial port with reset and power-down control
// Behaviour
// - power-up loads defaults, then aligns outputs
// - reset pin low forces all defaults
// - mirrored soft-reset bits hold defaults until cleared
// - soft reset acts without update command
// - sleep pin low powers down, settings kept
// - sleep kills PLL, dividers, outputs; port alive
// - async PLL power-down acts at update
// - sync PLL power-down waits for pump event
// - distribution power-down; set-clear triggers alignment
// - LVPECL two-bit power-down mode per output
// - each LVDS/CMOS output powers down alone
// - sample on SCLK rise, drive on fall
// - select bit moves readback to separate pin
// - chip select high keeps data pins released
// - chip select stall only on byte boundary
// - mid-byte select rise discards transfer
// - streaming steps address until select rises or the byte at the last address is done
// - long instruction only, bidirectional after reset
// - instruction: direction, length code, 13-bit address
// - length code 1, 2, 3 bytes or stream
// - writes buffered except port config; update bit copies all
// - MSB-first decrements, LSB-first increments address
`timescale 1ns/100ps
`include "csp_cfg.svh"
module cfg_serial_port #(
  parameter int REG_COUNT = 563,
  parameter int WBUF_DEPTH = 4
) (
  // clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_NRST,
  // serial link
  input  wire logic        I_SCLK,
  input  wire logic        I_CS_N,
  input  wire logic        I_SDIO,
  output logic             O_SDIO,
  output logic             O_SDIO_OE,
  output logic             O_SDO,
  output logic             O_SDO_OE,
  // power control inputs
  input  wire logic        I_SLEEP_N,
  input  wire logic        I_CP_EVENT,
  // power and alignment controls
  output logic             O_PLL_PD,
  output logic             O_VCO_PD,
  output logic             O_CLKIN_PD,
  output logic             O_DIV_PD,
  output logic             O_DIST_PD,
  output logic [3:0]       O_LVDS_PD,
  output logic [11:0]      O_PECL_MODE,
  output logic             O_SYNC,
  // write buffer status
  output logic             O_WBUF_READY
);
  import csp_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta, rst_n;
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // pin edges
  // ****************************************
  logic sclk_rise, sclk_fall, sleep_rise;
  pin_edge #(.RST_VAL(1'b0)) u_sclk (
    .i_clk(I_CLOCK), .i_rst_n(rst_n), .i_pin(I_SCLK),
    .o_rise(sclk_rise), .o_fall(sclk_fall));
  pin_edge #(.RST_VAL(1'b1)) u_sleep (
    .i_clk(I_CLOCK), .i_rst_n(rst_n), .i_pin(I_SLEEP_N),
    .o_rise(sleep_rise), .o_fall());

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0]  buf_reg [REG_COUNT];
  logic [7:0]  act_reg [REG_COUNT];
  logic [7:0]  port_cfg, next_port_cfg;
  logic        upd_copy, next_upd_copy;
  logic        srst, unidir, lsb_first;
  logic        fifo_valid, fifo_ready, wr_en;
  logic [17:0] fifo_data;
  reg_addr_t   wr_addr;
  logic [7:0]  wr_data;

  always_comb begin
    srst = port_cfg[`CSP_B_SRST] && port_cfg[`CSP_B_SRST_M];
    unidir    = port_cfg[`CSP_B_UNIDIR];
    lsb_first = port_cfg[`CSP_B_LSB];
    // drain pauses while the update copy runs
    fifo_ready = !upd_copy;
    wr_addr    = fifo_data[17:8];
    wr_data    = fifo_data[7:0];
    wr_en      = fifo_valid && fifo_ready;
    next_port_cfg = port_cfg;
    next_upd_copy = 1'b0;
    if (wr_en && wr_addr == `CSP_ADDR_PORTCFG) begin
      next_port_cfg = wr_data; // port settings act at once
    end
    if (wr_en && wr_addr == `CSP_ADDR_LAST) begin
      next_upd_copy = wr_data[`CSP_B_UPDATE];
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      port_cfg <= `CSP_PORTCFG_RST;
      upd_copy <= 1'b0;
      for (int i = 0; i < REG_COUNT; i++) begin
        buf_reg[i] <= `CSP_REG_RST;
        act_reg[i] <= `CSP_REG_RST;
      end
    end else begin
      port_cfg <= next_port_cfg;
      upd_copy <= next_upd_copy;
      if (srst) begin
        // port config itself is kept so the host can clear it
        for (int i = 1; i < REG_COUNT; i++) begin
          buf_reg[i] <= `CSP_REG_RST;
          act_reg[i] <= `CSP_REG_RST;
        end
      end else begin
        if (upd_copy) begin
          act_reg <= buf_reg;
        end
        if (wr_en && wr_addr != `CSP_ADDR_PORTCFG) begin
          // update bit self-clears: never stored
          buf_reg[wr_addr] <= (wr_addr == `CSP_ADDR_LAST) ?
            (wr_data & 8'hfe) : wr_data;
        end
      end
    end
  end

  // ****************************************
  // serial port state machine
  // ****************************************
  port_state_t state, next_state;
  logic [3:0]  bit_cnt, next_bit_cnt;
  logic [15:0] sr, next_sr, sr_in;
  logic        rd, next_rd;
  logic [1:0]  len, next_len, left, next_left;
  reg_addr_t   addr, next_addr, step_addr;
  logic        sdo_bit, next_sdo_bit, push, fifo_in_ready, last_byte;
  logic [7:0]  rx_byte, rd_byte;
  logic [2:0]  rd_idx;

  always_comb begin
    sr_in = lsb_first ? {I_SDIO, sr[15:1]} : {sr[14:0], I_SDIO};
    rx_byte = lsb_first ? sr_in[15:8] : sr_in[7:0];
    if (addr == `CSP_ADDR_PORTCFG) begin
      rd_byte = port_cfg;
    end else if (addr > `CSP_ADDR_LAST) begin
      rd_byte = 8'h00;
    end else if (buf_reg[`CSP_ADDR_RBSEL][`CSP_B_RBACTIVE]) begin
      rd_byte = act_reg[addr];
    end else begin
      rd_byte = buf_reg[addr];
    end
    rd_idx = lsb_first ? bit_cnt[2:0] : 3'h7 - bit_cnt[2:0];
    // MSB-first wraps from the bottom address to the top one
    if (lsb_first) begin
      step_addr = addr + 10'h001;
    end else if (addr == 10'h000) begin
      step_addr = `CSP_ADDR_LAST;
    end else begin
      step_addr = addr - 10'h001;
    end
    last_byte = (len == `CSP_LEN_STREAM) ? (addr == `CSP_ADDR_LAST) :
                (left == 2'h0);
    push = !I_CS_N && sclk_rise && state == ST_DATA && !rd &&
           bit_cnt == `CSP_BYTE_LAST && addr <= `CSP_ADDR_LAST;
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_sr      = sr;
    next_rd      = rd;
    next_len     = len;
    next_left    = left;
    next_addr    = addr;
    next_sdo_bit = sdo_bit;
    if (I_CS_N) begin
      // stall holds; mid-byte rise or stream end drops all
      if (bit_cnt[2:0] != 3'h0 ||
          (state == ST_DATA && len == `CSP_LEN_STREAM)) begin
        next_state   = ST_INSTR;
        next_bit_cnt = 4'h0;
      end
    end else if (sclk_rise) begin
      next_sr = sr_in;
      if (state == ST_INSTR) begin
        if (bit_cnt == `CSP_INSTR_LAST) begin
          next_rd      = sr_in[15];
          next_len     = sr_in[14:13];
          next_left    = sr_in[14:13];
          next_addr    = sr_in[9:0]; // upper address bits ignored
          next_state   = ST_DATA;
          next_bit_cnt = 4'h0;
        end else begin
          next_bit_cnt = bit_cnt + 4'h1;
        end
      end else if (bit_cnt == `CSP_BYTE_LAST) begin
        next_bit_cnt = 4'h0;
        next_addr    = step_addr;
        next_left    = left - 2'h1;
        if (last_byte) begin
          next_state = ST_INSTR;
        end
      end else begin
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end else if (sclk_fall && state == ST_DATA && rd) begin
      next_sdo_bit = rd_byte[rd_idx];
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ST_INSTR;
      bit_cnt <= 4'h0;
      sr      <= 16'h0000;
      rd      <= 1'b0;
      len     <= 2'h0;
      left    <= 2'h0;
      addr    <= 10'h000;
      sdo_bit <= 1'b0;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      sr      <= next_sr;
      rd      <= next_rd;
      len     <= next_len;
      left    <= next_left;
      addr    <= next_addr;
      sdo_bit <= next_sdo_bit;
    end
  end

  // bytes that arrive while the buffer is full are lost
  byte_fifo #(.WIDTH(18), .DEPTH(WBUF_DEPTH)) u_wbuf (
    .i_clk(I_CLOCK), .i_rst_n(rst_n),
    .i_in_valid(push), .o_in_ready(fifo_in_ready),
    .i_in_data({addr, rx_byte}),
    .o_out_valid(fifo_valid), .i_out_ready(fifo_ready),
    .o_out_data(fifo_data));

  always_comb begin
    O_WBUF_READY = fifo_in_ready;
    O_SDIO    = sdo_bit;
    O_SDO     = sdo_bit;
    O_SDIO_OE = !I_CS_N && state == ST_DATA && rd && !unidir;
    O_SDO_OE  = !I_CS_N && state == ST_DATA && rd && unidir;
  end

  // ****************************************
  // power-down and alignment
  // ****************************************
  logic       sleep, dist_now, ss_now, dist_q, ss_q, srst_q, por_pend;
  logic       next_pll_pd, next_sync, pll_off;
  logic [1:0] pll_mode;
  logic [3:0] next_lvds;
  logic [11:0] next_pecl;

  always_comb begin
    sleep    = !I_SLEEP_N;
    pll_mode = act_reg[`CSP_ADDR_PLLMODE][1:0];
    dist_now = act_reg[`CSP_ADDR_DIST][`CSP_B_DISTPD];
    ss_now   = act_reg[`CSP_ADDR_DIST][`CSP_B_SOFTSYNC];
    // sync mode: once off, stays off until the mode changes
    pll_off  = (pll_mode == `CSP_PLL_ASYNC) ||
               (pll_mode == `CSP_PLL_SYNC && (O_PLL_PD || I_CP_EVENT));
    next_pll_pd = sleep || pll_off;
    for (int i = 0; i < 4; i++) begin
      next_lvds[i] = sleep ||
        act_reg[`CSP_ADDR_LVDS0 + i][`CSP_B_LVDSPD];
    end
    for (int i = 0; i < 6; i++) begin
      next_pecl[2*i +: 2] = sleep ? `CSP_PECL_SAFE :
        act_reg[`CSP_ADDR_PECL0 + i][1:0];
    end
    next_sync = por_pend || sleep_rise || (dist_q && !dist_now) ||
                (srst_q && !srst) || (ss_q && !ss_now);
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_PLL_PD    <= 1'b1;
      O_VCO_PD    <= 1'b1;
      O_CLKIN_PD  <= 1'b1;
      O_DIV_PD    <= 1'b1;
      O_DIST_PD   <= 1'b0;
      O_LVDS_PD   <= 4'hf;
      O_PECL_MODE <= {6{`CSP_PECL_SAFE}};
      O_SYNC      <= 1'b0;
      por_pend    <= 1'b1;
      dist_q      <= 1'b0;
      ss_q        <= 1'b0;
      srst_q      <= 1'b0;
    end else begin
      O_PLL_PD    <= next_pll_pd;
      O_VCO_PD    <= sleep;
      O_CLKIN_PD  <= sleep;
      O_DIV_PD    <= sleep;
      O_DIST_PD   <= dist_now;
      O_LVDS_PD   <= next_lvds;
      O_PECL_MODE <= next_pecl;
      O_SYNC      <= next_sync;
      por_pend    <= 1'b0;
      dist_q      <= dist_now;
      ss_q        <= ss_now;
      srst_q      <= srst;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_hiz;
    @(posedge I_CLOCK) disable iff (!rst_n)
      I_CS_N |-> !O_SDIO_OE && !O_SDO_OE;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pins driven");
  property p_pinsel;
    @(posedge I_CLOCK) disable iff (!rst_n)
      O_SDIO_OE |-> !port_cfg[`CSP_B_UNIDIR];
  endproperty
  a_pinsel: assert property (p_pinsel) else $error("wrong pin");
  property p_sleep;
    @(posedge I_CLOCK) disable iff (!rst_n)
      !I_SLEEP_N |=> O_DIV_PD && O_LVDS_PD == 4'hf &&
        O_PECL_MODE == {6{`CSP_PECL_SAFE}} && O_PLL_PD;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep ignored");
  property p_async;
    @(posedge I_CLOCK) disable iff (!rst_n)
      pll_mode == `CSP_PLL_ASYNC |=> O_PLL_PD;
  endproperty
  a_async: assert property (p_async) else $error("pll on");
  property p_syncpd;
    @(posedge I_CLOCK) disable iff (!rst_n)
      pll_mode == `CSP_PLL_SYNC && !O_PLL_PD && !I_CP_EVENT && I_SLEEP_N
        |=> !O_PLL_PD;
  endproperty
  a_syncpd: assert property (p_syncpd) else $error("early off");
  property p_distsync;
    @(posedge I_CLOCK) disable iff (!rst_n)
      dist_q && !dist_now |=> O_SYNC && !O_DIST_PD;
  endproperty
  a_distsync: assert property (p_distsync) else $error("no sync");
  property p_abort;
    @(posedge I_CLOCK) disable iff (!rst_n)
      I_CS_N && bit_cnt[2:0] != 3'h0 |=> state == ST_INSTR && bit_cnt == 4'h0;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_stall;
    @(posedge I_CLOCK) disable iff (!rst_n)
      I_CS_N && bit_cnt == 4'h0 && state == ST_DATA &&
        len != `CSP_LEN_STREAM |=> state == ST_DATA && $stable(addr);
  endproperty
  a_stall: assert property (p_stall) else $error("stall lost");
  property p_srst;
    @(posedge I_CLOCK) disable iff (!rst_n)
      srst |=> act_reg[`CSP_ADDR_PLLMODE] == `CSP_REG_RST;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset");
  c_read: cover property (@(posedge I_CLOCK) O_SDIO_OE ##1 I_CS_N);
  c_stream: cover property (@(posedge I_CLOCK)
    state == ST_DATA && len == `CSP_LEN_STREAM && push);
  c_wake: cover property (@(posedge I_CLOCK) sleep_rise ##1 O_SYNC);
endmodule : cfg_serial_port

/* File: core/csp_cfg.svh */
// offsets, field positions, reset values and codes of the serial port block
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH
`define CSP_ADDR_W        10
`define CSP_ADDR_PORTCFG  10'h000
`define CSP_ADDR_RBSEL    10'h004
`define CSP_ADDR_PLLMODE  10'h010
`define CSP_ADDR_PECL0    10'h0f0
`define CSP_ADDR_LVDS0    10'h140
`define CSP_ADDR_DIST     10'h230
`define CSP_ADDR_LAST     10'h232
`define CSP_PORTCFG_RST   8'h18
`define CSP_REG_RST       8'h00
`define CSP_B_UNIDIR      0
`define CSP_B_LSB         1
`define CSP_B_SRST        2
`define CSP_B_SRST_M      5
`define CSP_B_RBACTIVE    0
`define CSP_B_SOFTSYNC    0
`define CSP_B_DISTPD      1
`define CSP_B_UPDATE      0
`define CSP_B_LVDSPD      0
`define CSP_LEN_STREAM    2'h3
`define CSP_PLL_ASYNC     2'h1
`define CSP_PLL_SYNC      2'h3
`define CSP_PECL_NORMAL   2'h0
`define CSP_PECL_SAFE     2'h2
`define CSP_INSTR_LAST    4'hf
`define CSP_BYTE_LAST     4'h7
`endif

/* File: core/csp_pkg.sv */
// types shared by the serial port block
package csp_pkg;
  typedef enum logic {ST_INSTR, ST_DATA} port_state_t;
  typedef logic [9:0] reg_addr_t;
endpackage : csp_pkg

/* File: core/byte_fifo.sv */
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // filling side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  always_comb begin
    o_in_ready  = (count != (AW+1)'(DEPTH));
    o_out_valid = (count != '0);
    o_out_data  = mem[rd_ptr];
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
    next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage carries no reset; only written entries are ever read
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule : byte_fifo

/* File: core/pin_edge.sv */
// edge finder for a pin sampled on the system clock
`timescale 1ns/100ps
module pin_edge #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // pin and its edges
  input  wire logic i_pin,
  output logic      o_rise,
  output logic      o_fall
);
  logic last, next_last;

  always_comb begin
    next_last = i_pin;
    o_rise    = i_pin && !last;
    o_fall    = !i_pin && last;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last <= RST_VAL;
    end else begin
      last <= next_last;
    end
  end
endmodule : pin_edge

/* File: verif/host_model.sv */
// serial bus master standing in for the host controller
`timescale 1ns/100ps
module host_model (
  // system clock
  input  wire logic i_clk,
  // serial link
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdio,
  output logic      o_sdio_oe,
  input  wire logic i_sdio,
  input  wire logic i_sdo
);
  // half period in system clocks: the port samples the serial clock
  localparam int HALF = 4;
  logic [7:0] wd [4];
  logic [7:0] rd [4];
  logic       use_sdo;
  logic       lsb;

  initial begin
    o_sclk    = 1'b0;
    o_cs_n    = 1'b1;
    o_sdio    = 1'b0;
    o_sdio_oe = 1'b0;
    use_sdo   = 1'b0;
    lsb       = 1'b0;
  end

  task automatic wait_n(input int k);
    repeat (k) @(negedge i_clk);
  endtask : wait_n

  // ****************************************************************
  // one transfer; cut stops after that many bits, stall lifts select
  // ****************************************************************
  task automatic xfer(input logic rw, input logic [1:0] len,
                      input logic [9:0] addr, input int n, input int cut,
                      input logic stall);
    logic [15:0] ins;
    int          nb;
    int          k;
    ins = {rw, len, 3'h0, addr};
    nb  = (cut > 0) ? cut : 16 + 8 * n;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      k = (i - 16) / 8;
      if (stall && i > 0 && i % 8 == 0) begin
        o_cs_n = 1'b1;
        wait_n(2 * HALF);
        o_cs_n = 1'b0;
        wait_n(HALF);
      end
      o_sclk    = 1'b0;
      o_sdio_oe = !(rw && i >= 16);
      // a released line toggles so a stale bit never reads as valid
      if (o_sdio_oe)
        o_sdio = (i < 16) ? ins[lsb ? i : 15 - i] :
                 wd[k][lsb ? i % 8 : 7 - i % 8];
      else
        o_sdio = ~o_sdio;
      wait_n(HALF);
      if (i >= 16)
        rd[k][lsb ? i % 8 : 7 - i % 8] = use_sdo ? i_sdo : i_sdio;
      o_sclk = 1'b1;
      // hand the shared line over before the port starts to drive it
      if (rw && i == 15)
        o_sdio_oe = 1'b0;
      wait_n(HALF);
    end
    o_sclk    = 1'b0;
    o_sdio_oe = 1'b0;
    wait_n(HALF);
    o_cs_n = 1'b1;
    wait_n(2 * HALF);
  endtask : xfer
endmodule : host_model

/* File: verif/tb_top.sv */
// self-checking bench for the configuration serial port
`timescale 1ns/100ps
module tb_top;
  logic        I_CLOCK, I_NRST, I_SLEEP_N, I_CP_EVENT;
  logic        sclk, cs_n, h_sdio, h_oe, sdio_w, sdo_w;
  logic        sdio_o, sdio_oe, sdo_o, sdo_oe, sync, wbuf_rdy;
  logic        pll_pd, vco_pd, clkin_pd, div_pd, dist_pd;
  logic [3:0]  lvds;
  logic [11:0] pecl;
  int          miscompares, n_checks, n_sync, n_oe_bad, n_clash;

  initial begin
    I_CLOCK = 1'b0;
    forever #5 I_CLOCK = ~I_CLOCK;
  end

  // the shared line: device wins while it drives, else the host
  assign sdio_w = sdio_oe ? sdio_o : h_sdio;
  assign sdo_w  = sdo_oe ? sdo_o : ~sdo_o;

  cfg_serial_port dut (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_SCLK(sclk),
    .I_CS_N(cs_n), .I_SDIO(sdio_w), .O_SDIO(sdio_o), .O_SDIO_OE(sdio_oe),
    .O_SDO(sdo_o), .O_SDO_OE(sdo_oe), .I_SLEEP_N(I_SLEEP_N),
    .I_CP_EVENT(I_CP_EVENT), .O_PLL_PD(pll_pd), .O_VCO_PD(vco_pd),
    .O_CLKIN_PD(clkin_pd), .O_DIV_PD(div_pd), .O_DIST_PD(dist_pd),
    .O_LVDS_PD(lvds), .O_PECL_MODE(pecl), .O_SYNC(sync),
    .O_WBUF_READY(wbuf_rdy));

  host_model h (.i_clk(I_CLOCK), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_sdio(h_sdio), .o_sdio_oe(h_oe), .i_sdio(sdio_w), .i_sdo(sdo_w));

  always @(posedge I_CLOCK) begin
    if (sync === 1'b1) n_sync++;
    if (cs_n && (sdio_oe || sdo_oe)) n_oe_bad++;
    if (h_oe && sdio_oe) n_clash++;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [11:0] exp,
                     input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic wr1(input logic [9:0] a, input logic [7:0] d);
    h.wd[0] = d;
    h.xfer(1'b0, 2'h0, a, 1, 0, 1'b0);
  endtask : wr1

  task automatic upd();
    wr1(10'h232, 8'h01);
    repeat (10) @(negedge I_CLOCK);
  endtask : upd

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic do_reset();
    int s;
    s = n_sync;
    I_NRST = 1'b0;
    repeat (16) @(negedge I_CLOCK);
    chk("lvds pd in reset", 12'hf, lvds);
    chk("pecl in reset", 12'haaa, pecl);
    I_NRST = 1'b1;
    repeat (8) @(negedge I_CLOCK);
    chk("lvds pd after reset", 12'h0, lvds);
    chk("pll pd after reset", 12'h0, pll_pd);
    chk("power-up alignment", s + 1, n_sync);
    chk("buffer ready idle", 12'h1, wbuf_rdy);
  endtask : do_reset

  task automatic t_write();
    wr1(10'h140, 8'h01);
    repeat (10) @(negedge I_CLOCK);
    chk("lvds pd before update", 12'h0, lvds);
    upd();
    chk("lvds pd after update", 12'h1, lvds);
  endtask : t_write

  task automatic t_multi();
    h.wd[0] = 8'h03;
    h.wd[1] = 8'h02;
    h.wd[2] = 8'h00;
    h.xfer(1'b0, 2'h2, 10'h0f2, 3, 0, 1'b1);
    upd();
    chk("pecl modes", 12'h038, pecl);
  endtask : t_multi

  task automatic t_read();
    h.xfer(1'b1, 2'h0, 10'h0f2, 1, 0, 1'b0);
    chk("read shared line", 12'h03, h.rd[0]);
    wr1(10'h000, 8'h99);
    h.use_sdo = 1'b1;
    h.xfer(1'b1, 2'h1, 10'h0f1, 2, 0, 1'b0);
    chk("read sdo byte 0", 12'h02, h.rd[0]);
    chk("read sdo byte 1", 12'h00, h.rd[1]);
    h.use_sdo = 1'b0;
    wr1(10'h000, 8'h18);
  endtask : t_read

  task automatic t_abort_stream();
    h.wd[0] = 8'h01;
    h.xfer(1'b0, 2'h0, 10'h143, 1, 20, 1'b0);
    upd();
    chk("lvds after abort", 12'h1, lvds);
    for (int i = 0; i < 4; i++) h.wd[i] = 8'h01;
    h.xfer(1'b0, 2'h3, 10'h143, 4, 0, 1'b0);
    upd();
    chk("lvds after stream", 12'hf, lvds);
  endtask : t_abort_stream

  task automatic t_pll();
    wr1(10'h010, 8'h01);
    upd();
    chk("pll async pd", 12'h1, pll_pd);
    wr1(10'h010, 8'h00);
    upd();
    wr1(10'h010, 8'h03);
    upd();
    chk("pll sync pd waits", 12'h0, pll_pd);
    I_CP_EVENT = 1'b1;
    @(negedge I_CLOCK);
    I_CP_EVENT = 1'b0;
    repeat (3) @(negedge I_CLOCK);
    chk("pll sync pd at pump", 12'h1, pll_pd);
    wr1(10'h010, 8'h00);
    upd();
  endtask : t_pll

  task automatic t_dist();
    int s;
    s = n_sync;
    wr1(10'h230, 8'h02);
    upd();
    chk("dist pd set", 12'h1, dist_pd);
    wr1(10'h230, 8'h00);
    upd();
    chk("dist pd clear", 12'h0, dist_pd);
    chk("dist alignment", s + 1, n_sync);
  endtask : t_dist

  task automatic t_sleep();
    int s;
    s = n_sync;
    I_SLEEP_N = 1'b0;
    repeat (4) @(negedge I_CLOCK);
    chk("sleep pd", 12'hf, {pll_pd, vco_pd, clkin_pd, div_pd});
    chk("sleep pecl", 12'haaa, pecl);
    wr1(10'h141, 8'h00);
    upd();
    chk("sleep lvds", 12'hf, lvds);
    I_SLEEP_N = 1'b1;
    repeat (4) @(negedge I_CLOCK);
    chk("wake lvds", 12'hd, lvds);
    chk("wake pecl", 12'h038, pecl);
    chk("wake alignment", s + 1, n_sync);
    // host asks for its own alignment through the soft sync bit
    wr1(10'h230, 8'h01);
    upd();
    wr1(10'h230, 8'h00);
    upd();
    chk("host alignment after wake", s + 2, n_sync);
  endtask : t_sleep

  task automatic t_lsb();
    wr1(10'h000, 8'h5a);
    h.lsb   = 1'b1;
    h.wd[0] = 8'h03;
    h.wd[1] = 8'h02;
    h.xfer(1'b0, 2'h1, 10'h0f4, 2, 0, 1'b0);
    wr1(10'h004, 8'h01);
    h.xfer(1'b1, 2'h1, 10'h0f4, 2, 0, 1'b0);
    chk("active before update", 12'h00, h.rd[0]);
    upd();
    chk("pecl after lsb write", 12'hb38, pecl);
    h.xfer(1'b1, 2'h1, 10'h0f4, 2, 0, 1'b0);
    chk("lsb read byte 0", 12'h03, h.rd[0]);
    chk("lsb read byte 1", 12'h02, h.rd[1]);
    wr1(10'h004, 8'h00);
    wr1(10'h000, 8'h18);
    h.lsb = 1'b0;
  endtask : t_lsb

  task automatic t_soft();
    int s;
    s = n_sync;
    wr1(10'h000, 8'h3c);
    repeat (10) @(negedge I_CLOCK);
    chk("soft reset lvds", 12'h0, lvds);
    chk("soft reset pecl", 12'h0, pecl);
    wr1(10'h000, 8'h18);
    chk("soft reset end sync", s + 1, n_sync);
    wr1(10'h140, 8'h01);
    upd();
    chk("port after soft reset", 12'h1, lvds);
  endtask : t_soft

  initial begin
    I_NRST     = 1'b0;
    I_SLEEP_N  = 1'b1;
    I_CP_EVENT = 1'b0;
    do_reset();
    t_write();
    t_multi();
    t_read();
    t_abort_stream();
    t_pll();
    t_dist();
    t_sleep();
    t_lsb();
    t_soft();
    do_reset();
    chk("oe while deselected", 12'h0, n_oe_bad);
    chk("line driven by both", 12'h0, n_clash);
    end_sim();
  end

  // a stuck handshake must not hang the run
  initial begin
    repeat (60000) @(posedge I_CLOCK);
    miscompares++;
    end_sim();
  end
endmodule : tb_top
